/* File: dv/ipus_far_side.sv */
module ipus_far_side #(
  parameter ipus_pkg::ipus_sample_t CUR = '0,
  parameter ipus_pkg::ipus_sample_t V1  = '0,
  parameter ipus_pkg::ipus_sample_t V2  = '0
) (
  input  wire logic                   i_run,
  output logic                        o_input_clock,
  output ipus_pkg::ipus_sample_t      o_current,
  output ipus_pkg::ipus_sample_t      o_volt1,
  output ipus_pkg::ipus_sample_t      o_volt2
);
  timeunit 1ns;
  timeprecision 1ps;
  import ipus_pkg::*;
  assign o_current = CUR;
  assign o_volt1   = V1;
  assign o_volt2   = V2;
  // Odd offset keeps link edges off the system clock edges
  initial
  begin
    o_input_clock = 1'b0;
    #3;
    forever
    begin
      #80;
      o_input_clock = i_run ? ~o_input_clock : 1'b0;
    end
  end
endmodule

/* File: dv/ipus_top_props.sv */
module ipus_top_chk #(
  parameter int unsigned RESET_PENDING_CYC = 50,
  parameter int unsigned ISO_READY_CYC     = 200
) (
  input wire logic                 I_CLK,
  input wire logic                 I_RST_B,
  input wire logic                 I_PSEL,
  input wire logic                 I_PENABLE,
  input wire logic                 I_PWRITE,
  input wire ipus_pkg::ipus_addr_t I_PADDR,
  input wire ipus_pkg::ipus_word_t O_PRDATA,
  input wire logic                 O_PREADY,
  input wire logic                 O_PSLVERR,
  input wire logic                 O_CLOCK_OR_READY_PIN,
  input wire logic                 O_ISOLATED_ON
);
  timeunit 1ns;
  timeprecision 1ps;
  import ipus_pkg::*;
  int unsigned cyc;
  int unsigned low_cnt;
  logic        pwr_rd;
  assign pwr_rd = O_PREADY && !I_PWRITE && I_PADDR == 8'h24;
  always_ff @(posedge I_CLK or negedge I_RST_B)
    if (!I_RST_B)
      cyc <= 0;
    else if (cyc < 32'h00FF_FFFF)
      cyc <= cyc + 1;
  always_ff @(posedge I_CLK or negedge I_RST_B)
    if (!I_RST_B)
      low_cnt <= 0;
    else
      low_cnt <= O_CLOCK_OR_READY_PIN ? 0 : low_cnt + 1;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence
  sequence s_access;
    I_PSEL && I_PENABLE && O_PREADY;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  a_pin_reset_high: assert property ($rose(I_RST_B) |-> O_CLOCK_OR_READY_PIN [*3])
    else $error("pin not idle high after reset");
  a_pend_set_early: assert property (pwr_rd && cyc + 3 < RESET_PENDING_CYC |-> O_PRDATA[0])
    else $error("pending flag cleared too early");
  a_pend_clear_late: assert property (pwr_rd && cyc > RESET_PENDING_CYC + 3 |-> !O_PRDATA[0])
    else $error("pending flag not cleared");
  a_iso_rise_time: assert property ($rose(O_ISOLATED_ON)
    |-> cyc inside {[ISO_READY_CYC - 2 : ISO_READY_CYC + 3]})
    else $error("isolated ready at wrong time");
  a_iso_not_late: assert property (cyc == ISO_READY_CYC + 4 |-> O_ISOLATED_ON)
    else $error("isolated ready missing");
  a_strobe_len: assert property ($rose(O_CLOCK_OR_READY_PIN) && low_cnt > 32
    |-> low_cnt inside {[1004 : 1040]})
    else $error("strobe length wrong");
endmodule

bind ipus_top ipus_top_chk #(
  .RESET_PENDING_CYC(RESET_PENDING_CYC),
  .ISO_READY_CYC    (ISO_READY_CYC)
) u_ipus_top_chk (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_CLOCK_OR_READY_PIN(O_CLOCK_OR_READY_PIN),
  .O_ISOLATED_ON(O_ISOLATED_ON)
);

/* File: dv/ipus_top_test.sv */
module ipus_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ipus_pkg::*;
  localparam ipus_sample_t C_CUR = 24'h12_3456;
  localparam ipus_sample_t C_V1  = 24'hA5_0F3C;
  localparam ipus_sample_t C_V2  = 24'h7E_81C3;
  logic         clk;
  logic         rst_b;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic         run;
  logic         pready;
  logic         pslverr;
  logic         in_clk;
  logic         pin;
  logic         iso_on;
  logic         irq;
  logic         err;
  logic         last;
  ipus_addr_t   paddr;
  ipus_word_t   pwdata;
  ipus_word_t   prdata;
  ipus_word_t   rd;
  ipus_sample_t cur;
  ipus_sample_t v1;
  ipus_sample_t v2;
  ipus_byte_t   slots;
  int           bad_count;
  int           total_checks;
  int           n;

  ipus_far_side #(.CUR(C_CUR), .V1(C_V1), .V2(C_V2)) u_ipus_far_side (
    .i_run(run), .o_input_clock(in_clk),
    .o_current(cur), .o_volt1(v1), .o_volt2(v2));
  ipus_top #(.RESET_PENDING_CYC(50), .ISO_READY_CYC(200)) u_ipus_top (
    .I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_INPUT_CLOCK(in_clk),
    .I_CURRENT_DATA(cur), .I_VOLT1_DATA(v1), .I_VOLT2_DATA(v2),
    .O_CLOCK_OR_READY_PIN(pin), .O_EMISSION_SLOTS(slots),
    .O_ISOLATED_ON(iso_on), .O_IRQ(irq));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input ipus_word_t seen, input ipus_word_t exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timed_out;
    bad_count++;
    $display("FAIL %0t wait timed out", $time);
    give_verdict;
  endtask

  task automatic apb(input logic wr, input ipus_addr_t a, input ipus_word_t wd);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      timed_out;
    @(posedge clk);
  endtask

  task automatic test_reset;
    apb(1'b0, 8'h24, 32'h0);
    check(rd & 32'h1, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(rd, 32'hFF);
    check({24'h0, slots}, 32'hFF);
    check({31'h0, pin}, 32'h1);
    apb(1'b0, 8'h80, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test_reset done");
  endtask

  task automatic test_poll;
    run <= 1'b1;
    rd = 32'h1;
    for (n = 0; n < 40 && rd[0] !== 1'b0; n++)
      apb(1'b0, 8'h24, 32'h0);
    if (rd[0] !== 1'b0)
      timed_out;
    apb(1'b0, 8'h44, 32'h0);
    check(rd & 32'h2, 32'h2);
    check({31'h0, irq}, 32'h0);
    $display("test_poll done");
  endtask

  task automatic test_lock;
    apb(1'b1, 8'h20, 32'h0);
    apb(1'b1, 8'h40, 32'h55);
    apb(1'b1, 8'h28, 32'hCA);
    apb(1'b1, 8'h40, 32'hAA);
    apb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h55);
    check({24'h0, slots}, 32'h55);
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h5555);
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b1, 8'h2C, 32'h1);
    apb(1'b1, 8'h2C, 32'h2);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, rd <= 32'h1}, 32'h1);
    $display("test_lock done");
  endtask

  task automatic test_strobe;
    apb(1'b1, 8'h48, 32'h1);
    for (n = 0; n < 20000 && pin !== 1'b0; n++)
      @(posedge clk);
    if (pin !== 1'b0)
      timed_out;
    check({31'h0, iso_on}, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, {8'h0, C_CUR});
    apb(1'b0, 8'h04, 32'h0);
    check(rd, {8'h0, C_V1});
    apb(1'b0, 8'h08, 32'h0);
    check(rd, {8'h0, C_V2});
    apb(1'b0, 8'h24, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, {16'h0, C_CUR[15:0] ^ C_V1[15:0] ^ C_V2[15:0]
      ^ {8'h0, C_CUR[23:16] ^ C_V1[23:16] ^ C_V2[23:16]}});
    for (n = 0; n < 1100 && pin !== 1'b1; n++)
      @(posedge clk);
    check({31'h0, n > 900 && n < 1040}, 32'h1);
    apb(1'b1, 8'h44, 32'h1);
    // Interrupt output is one flop behind the status
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    // Phase counter stands at 64 input edges past the event here
    apb(1'b1, 8'h2C, 32'h2);
    apb(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h40);
    apb(1'b1, 8'h2C, 32'h1);
    apb(1'b1, 8'h28, 32'hCA);
    apb(1'b1, 8'h2C, 32'h2);
    apb(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h40);
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b1, 8'h2C, 32'h2);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, rd <= 32'h1}, 32'h1);
    $display("test_strobe done");
  endtask

  task automatic test_clkout;
    apb(1'b1, 8'h20, 32'h1);
    last = pin;
    n = 0;
    repeat (320)
    begin
      @(posedge clk);
      if (pin !== last)
        n++;
      last = pin;
    end
    check({31'h0, n >= 36 && n <= 44}, 32'h1);
    apb(1'b1, 8'h20, 32'h0);
    @(posedge clk);
    check({31'h0, pin}, 32'h1);
    $display("test_clkout done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever
      #5 clk = ~clk;
  end

  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    run = 1'b0;
    bad_count = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    test_reset;
    test_poll;
    test_lock;
    test_strobe;
    test_clkout;
    give_verdict;
  end
endmodule

/* File: hw/ipus_cfg.svh */
`ifndef IPUS_CFG_SVH
`define IPUS_CFG_SVH

// Clock and timing
`define IPUS_CLK_HZ            100000000
`define IPUS_RESET_PENDING_MS  20
`define IPUS_ISO_READY_MS      100
`define IPUS_RESET_PENDING_CYC (`IPUS_RESET_PENDING_MS * (`IPUS_CLK_HZ / 1000))
`define IPUS_ISO_READY_CYC     (`IPUS_ISO_READY_MS * (`IPUS_CLK_HZ / 1000))
`define IPUS_STROBE_INPUT_CLOCK      7'd64
`define IPUS_CONV_PERIOD       16'h0400

// Register indices; byte address is index times four
`define IPUS_IDX_CURRENT       6'h00
`define IPUS_IDX_VOLT1         6'h01
`define IPUS_IDX_VOLT2         6'h02
`define IPUS_IDX_RSVD0         6'h03
`define IPUS_IDX_SAMPLE_CS     6'h04
`define IPUS_IDX_CONFIG_CS     6'h05
`define IPUS_IDX_RSVD1         6'h06
`define IPUS_IDX_CAPTURED      6'h07
`define IPUS_IDX_SETUP         6'h08
`define IPUS_IDX_POWER_STATUS  6'h09
`define IPUS_IDX_LOCK          6'h0A
`define IPUS_IDX_ALIGN_CMD     6'h0B
`define IPUS_IDX_EMISSION      6'h10
`define IPUS_IDX_IRQ_STATUS    6'h11
`define IPUS_IDX_IRQ_MASK      6'h12

// Field positions and values
`define IPUS_SETUP_CLKOUT_BIT  0
`define IPUS_PWR_PENDING_BIT   0
`define IPUS_PWR_ISO_BIT       1
`define IPUS_IRQ_DATA_BIT      0
`define IPUS_IRQ_NONISO_BIT    1
`define IPUS_IRQ_ISO_BIT       2
`define IPUS_LOCK_KEY          8'hCA
`define IPUS_ALIGN_RESET       8'h01
`define IPUS_ALIGN_SNAPSHOT    8'h02

// Reset values
`define IPUS_SETUP_RST         8'h00
`define IPUS_EMISSION_RST      8'hFF
`define IPUS_IRQ_MASK_RST      3'h0

`endif

/* File: hw/ipus_pkg.sv */
package ipus_pkg;
  typedef logic [7:0]  ipus_addr_t;
  typedef logic [31:0] ipus_word_t;
  typedef logic [23:0] ipus_sample_t;
  typedef logic [7:0]  ipus_byte_t;

  typedef enum logic [1:0]
  {
    ST_STARTING,
    ST_NONISO_READY,
    ST_RUNNING
  } ipus_pwr_state_t;
endpackage

/* File: hw/ipus_top.sv */
// Decided for this implementation: the APB register port and the register offsets.
`include "ipus_cfg.svh"

module ipus_top #(
  parameter int unsigned RESET_PENDING_CYC = `IPUS_RESET_PENDING_CYC,
  parameter int unsigned ISO_READY_CYC     = `IPUS_ISO_READY_CYC
) (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST_B,
  input  wire logic                  I_PSEL,
  input  wire logic                  I_PENABLE,
  input  wire logic                  I_PWRITE,
  input  wire ipus_pkg::ipus_addr_t  I_PADDR,
  input  wire ipus_pkg::ipus_word_t  I_PWDATA,
  output ipus_pkg::ipus_word_t       O_PRDATA,
  output logic                       O_PREADY,
  output logic                       O_PSLVERR,
  input  wire logic                  I_INPUT_CLOCK,
  input  wire ipus_pkg::ipus_sample_t I_CURRENT_DATA,
  input  wire ipus_pkg::ipus_sample_t I_VOLT1_DATA,
  input  wire ipus_pkg::ipus_sample_t I_VOLT2_DATA,
  output logic                       O_CLOCK_OR_READY_PIN,
  output ipus_pkg::ipus_byte_t       O_EMISSION_SLOTS,
  output logic                       O_ISOLATED_ON,
  output logic                       O_IRQ
);
  import ipus_pkg::*;

  ipus_pwr_state_t pwr_state;
  logic [23:0]     up_count;
  logic [2:0]      input_clock_sync;
  logic            input_clock_tick;
  logic [15:0]     phase_count;
  logic [6:0]      strobe_left;
  logic            conv_event;
  ipus_sample_t    current_sample_reg;
  ipus_sample_t    first_voltage_sample_reg;
  ipus_sample_t    second_voltage_sample_reg;
  logic [15:0]     sample_checksum;
  logic [15:0]     captured_count_reg;
  ipus_byte_t      setup_reg;
  ipus_byte_t      emission_slot_reg;
  logic            locked;
  logic [2:0]      irq_status;
  logic [2:0]      irq_mask;
  logic [2:0]      irq_event;
  logic            clock_output_enable;
  logic            acc_write;
  logic            setup_phase;
  logic [5:0]      idx;
  logic            cfg_open;
  ipus_word_t      next_prdata;
  logic            next_pslverr;

  assign idx                 = I_PADDR[7:2];
  assign setup_phase         = I_PSEL && !I_PENABLE;
  assign acc_write           = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  assign cfg_open            = !locked;
  assign clock_output_enable = setup_reg[`IPUS_SETUP_CLKOUT_BIT];

  // Power-up timing; both flags count from reset release
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      up_count  <= 24'h00_0000;
      pwr_state <= ST_STARTING;
    end
    else
    begin
      if (pwr_state != ST_RUNNING)
        up_count <= up_count + 24'h00_0001;
      case (pwr_state)
        ST_STARTING:
          if (up_count == 24'(RESET_PENDING_CYC - 1))
            pwr_state <= ST_NONISO_READY;
        ST_NONISO_READY:
          if (up_count == 24'(ISO_READY_CYC - 1))
            pwr_state <= ST_RUNNING;
        default:
          pwr_state <= ST_RUNNING;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_ISOLATED_ON <= 1'b0;
    else
      O_ISOLATED_ON <= (pwr_state == ST_RUNNING);
  end

  // Input clock synchroniser; only stages 1 and 2 feed logic
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      input_clock_sync <= 3'h0;
    else
      input_clock_sync <= {input_clock_sync[1:0], I_INPUT_CLOCK};
  end

  assign input_clock_tick = input_clock_sync[1] && !input_clock_sync[2];

  // Conversion phase counter; stands still until the isolated side is up
  assign conv_event = input_clock_tick && (pwr_state == ST_RUNNING) &&
                      (phase_count == `IPUS_CONV_PERIOD - 16'h0001);

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      phase_count <= 16'h0000;
    else if (acc_write && idx == `IPUS_IDX_ALIGN_CMD && cfg_open &&
             I_PWDATA[7:0] == `IPUS_ALIGN_RESET)
      phase_count <= 16'h0000;
    else if (conv_event)
      phase_count <= 16'h0000;
    else if (input_clock_tick && pwr_state == ST_RUNNING)
      phase_count <= phase_count + 16'h0001;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      captured_count_reg <= 16'h0000;
    else if (acc_write && idx == `IPUS_IDX_ALIGN_CMD && cfg_open &&
             I_PWDATA[7:0] == `IPUS_ALIGN_SNAPSHOT)
      captured_count_reg <= phase_count;
  end

  // Strobe length counted in input clock edges, not system cycles
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      strobe_left <= 7'd0;
    else if (conv_event)
      strobe_left <= `IPUS_STROBE_INPUT_CLOCK;
    else if (input_clock_tick && strobe_left != 7'd0)
      strobe_left <= strobe_left - 7'd1;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_CLOCK_OR_READY_PIN <= 1'b1;
    else if (clock_output_enable)
      O_CLOCK_OR_READY_PIN <= input_clock_sync[1];
    else
      O_CLOCK_OR_READY_PIN <= (strobe_left == 7'd0);
  end

  // Samples latched together so a burst read sees one coherent set
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      current_sample_reg        <= 24'h00_0000;
      first_voltage_sample_reg  <= 24'h00_0000;
      second_voltage_sample_reg <= 24'h00_0000;
      sample_checksum           <= 16'h0000;
    end
    else if (conv_event)
    begin
      current_sample_reg        <= I_CURRENT_DATA;
      first_voltage_sample_reg  <= I_VOLT1_DATA;
      second_voltage_sample_reg <= I_VOLT2_DATA;
      sample_checksum           <= I_CURRENT_DATA[15:0] ^ {8'h00, I_CURRENT_DATA[23:16]} ^
                                   I_VOLT1_DATA[15:0] ^ {8'h00, I_VOLT1_DATA[23:16]} ^
                                   I_VOLT2_DATA[15:0] ^ {8'h00, I_VOLT2_DATA[23:16]};
    end
  end

  // Configuration; writes ignored while locked
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      setup_reg         <= `IPUS_SETUP_RST;
      emission_slot_reg <= `IPUS_EMISSION_RST;
    end
    else if (acc_write && cfg_open)
    begin
      if (idx == `IPUS_IDX_SETUP)
        setup_reg <= I_PWDATA[7:0];
      else if (idx == `IPUS_IDX_EMISSION)
        emission_slot_reg <= I_PWDATA[7:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_EMISSION_SLOTS <= `IPUS_EMISSION_RST;
    else
      O_EMISSION_SLOTS <= emission_slot_reg;
  end

  // Key locks; any other value unlocks
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      locked <= 1'b0;
    else if (acc_write && idx == `IPUS_IDX_LOCK)
      locked <= (I_PWDATA[7:0] == `IPUS_LOCK_KEY);
  end

  // Interrupt status: set beats write-one-to-clear
  assign irq_event[`IPUS_IRQ_DATA_BIT]   = conv_event;
  assign irq_event[`IPUS_IRQ_NONISO_BIT] = (pwr_state == ST_STARTING) &&
                                           (up_count == 24'(RESET_PENDING_CYC - 1));
  assign irq_event[`IPUS_IRQ_ISO_BIT]    = (pwr_state == ST_NONISO_READY) &&
                                           (up_count == 24'(ISO_READY_CYC - 1));

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      irq_status <= 3'h0;
    else if (acc_write && idx == `IPUS_IDX_IRQ_STATUS)
      irq_status <= (irq_status & ~I_PWDATA[2:0]) | irq_event;
    else
      irq_status <= irq_status | irq_event;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      irq_mask <= `IPUS_IRQ_MASK_RST;
    else if (acc_write && idx == `IPUS_IDX_IRQ_MASK)
      irq_mask <= I_PWDATA[2:0];
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= |(irq_status & irq_mask);
  end

  // Read mux evaluated in setup phase so read data comes from a flop
  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (idx == `IPUS_IDX_CURRENT)
      next_prdata = {8'h00, current_sample_reg};
    else if (idx == `IPUS_IDX_VOLT1)
      next_prdata = {8'h00, first_voltage_sample_reg};
    else if (idx == `IPUS_IDX_VOLT2)
      next_prdata = {8'h00, second_voltage_sample_reg};
    else if (idx == `IPUS_IDX_RSVD0 || idx == `IPUS_IDX_RSVD1)
      next_prdata = 32'h0000_0000;
    else if (idx == `IPUS_IDX_SAMPLE_CS)
      next_prdata = {16'h0000, sample_checksum};
    else if (idx == `IPUS_IDX_CONFIG_CS)
      next_prdata = {16'h0000, setup_reg ^ emission_slot_reg, emission_slot_reg};
    else if (idx == `IPUS_IDX_CAPTURED)
      next_prdata = {16'h0000, captured_count_reg};
    else if (idx == `IPUS_IDX_SETUP)
      next_prdata = {24'h00_0000, setup_reg};
    else if (idx == `IPUS_IDX_POWER_STATUS)
      next_prdata = {30'h0000_0000, pwr_state == ST_RUNNING,
                     pwr_state == ST_STARTING};
    else if (idx == `IPUS_IDX_LOCK || idx == `IPUS_IDX_ALIGN_CMD)
      next_prdata = 32'h0000_0000;
    else if (idx == `IPUS_IDX_EMISSION)
      next_prdata = {24'h00_0000, emission_slot_reg};
    else if (idx == `IPUS_IDX_IRQ_STATUS)
      next_prdata = {29'h0000_0000, irq_status};
    else if (idx == `IPUS_IDX_IRQ_MASK)
      next_prdata = {29'h0000_0000, irq_mask};
    else
      next_pslverr = 1'b1;
    if (I_PWRITE)
      next_prdata = 32'h0000_0000;
  end

  // No wait state: ready rises in the first access cycle
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else if (setup_phase)
    begin
      O_PREADY  <= 1'b1;
      O_PRDATA  <= next_prdata;
      O_PSLVERR <= next_pslverr;
    end
    else
    begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
  end
endmodule
